// ===== dv/dctd_decoder_test.sv
// Self-checking bench for the duty-cycle thermometer decoder
`timescale 1ns/1ps
module dctd_decoder_test;
  import dctd_pkg::*;
  typedef struct {
    logic hi;
    int   us;
    logic vld;
    int   oth;
  } dctd_note_t;

  logic       sys_clk;
  logic       rst_b;
  logic       pin;
  dctd_meas_t meas;
  dctd_temp_t temp;
  int         num_errors;
  int         check_count;
  dctd_note_t per_q[$];
  int         temp_q[$];
  dctd_note_t n;
  logic [7:0] lfsr_q;
  logic       armed;
  int         h;
  int         l;
  int         pl;

  always #25 sys_clk = ~sys_clk;

  dctd_decoder uut (
    .sys_clk          (sys_clk),
    .rst_b            (rst_b),
    .sensor_flag_input(pin),
    .meas             (meas),
    .temp             (temp)
  );

  dctd_sensor_model sensor (
    .pin(pin)
  );

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Counts lag by about one tick, and the ratio loses a little in truncation
  function automatic int exp_temp(input int hu, input int lu);
    return 940 - (1600 * (hu - 1)) / (lu - 1);
  endfunction

  task automatic check(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic cmp_period(input logic [15:0] got, input int us);
    check((^got !== 1'bx) && got >= 16'(us - 2) && got <= 16'(us), "period count");
  endtask

  task automatic cmp_temp(input logic signed [15:0] got, input int e);
    check((^got !== 1'bx) && int'(got) >= e - 6 && int'(got) <= e + 6, "temperature");
  endtask

  task automatic cmp_flag(input logic got, input logic e);
    check(got === e, "flag value");
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Capture monitor: compares each phase count with the oldest note
  always @(posedge sys_clk) begin
    if (meas.edge_pulse === 1'b1) begin
      if (!armed) begin
        armed = 1'b1;
      end else begin
        repeat (3) @(posedge sys_clk);
        #1;
        check(per_q.size() > 0, "unexpected capture");
        if (per_q.size() > 0) begin
          n = per_q.pop_front();
          cmp_period(n.hi ? meas.high_period : meas.low_period, n.us);
          if (n.vld) cmp_period(n.hi ? meas.low_period : meas.high_period, n.oth);
          cmp_flag(meas.level, ~n.hi);
          cmp_flag(meas.valid, n.vld);
          cmp_flag(meas.error, 1'b0);
        end
      end
    end
  end

  // Temperature monitor
  always @(posedge sys_clk) begin
    if (temp.done === 1'b1) begin
      #1;
      check(temp_q.size() > 0, "unexpected temperature");
      if (temp_q.size() > 0) cmp_temp(temp.temp, temp_q.pop_front());
      cmp_flag(temp.temp_valid, 1'b1);
    end
  end

  initial begin
    sys_clk     = 1'b0;
    rst_b       = 1'b0;
    num_errors  = 0;
    check_count = 0;
    lfsr_q      = 8'h10;
    armed       = 1'b0;
    pl          = 0;
    repeat (2) @(posedge sys_clk);
    #2;
    rst_b = 1'b1;
    repeat (6) @(posedge sys_clk);
    #2;
    cmp_flag(meas.valid, 1'b0);
    cmp_flag(meas.level, 1'b0);
    cmp_flag(temp.temp_valid, 1'b0);
    // Ratio kept inside 0.31..0.69, the range the quotient is sized for
    for (int k = 0; k < 3; k++) begin
      h      = 170 + int'(lfsr_q) % 140;
      lfsr_q = lfsr_next(lfsr_q);
      l      = 450 + int'(lfsr_q) % 100;
      lfsr_q = lfsr_next(lfsr_q);
      per_q.push_back('{1'b1, h, k > 0, pl});
      if (k > 0) temp_q.push_back(exp_temp(h, pl));
      sensor.drive(1'b1, h);
      per_q.push_back('{1'b0, l, 1'b1, h});
      temp_q.push_back(exp_temp(h, l));
      sensor.drive(1'b0, l);
      pl = l;
    end
    sensor.drive(1'b1, 60);
    check(per_q.size() == 0 && temp_q.size() == 0, "results missing");
    wrap_up();
  end

  // Three periods take under 3 ms; allow 4 ms
  initial begin
    #4_000_000;
    num_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    wrap_up();
  end
endmodule

// ===== dv/dctd_sensor_model.sv
// Behavioural duty-cycle sensor that drives the decoder's input pin
`timescale 1ns/1ps
module dctd_sensor_model (
  output logic pin
);
  initial begin
    pin = 1'b0;
  end

  // Push-pull output holds one level for a whole phase, never past 32 ms
  task automatic drive(input logic lvl, input int us);
    pin = lvl;
    #(((us > 32000) ? 32000 : us) * 1000);
  endtask
endmodule

// ===== hw/dctd_decoder.sv
// Duty-cycle thermometer decoder: sync, phase counter, capture and temperature
`timescale 1ns/1ps
module dctd_decoder (
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic            sensor_flag_input,
  output dctd_pkg::dctd_meas_t meas,
  output dctd_pkg::dctd_temp_t temp
);
  import dctd_pkg::*;

  typedef struct packed {
    logic [2:0]  sync;
    logic        primed;
    logic        lvl;
    logic [7:0]  presc;
    logic        tick;
    logic [7:0]  cnt_hi;
    logic [7:0]  cnt_lo;
    logic        got_hi;
    logic        got_lo;
    logic        div_go;
    dctd_state_t st;
    dctd_meas_t  out;
  } dctd_top_state_t;

  dctd_top_state_t s_q, s_d;
  logic            evt;
  logic [15:0]     elapsed;
  dctd_temp_t      temp_w;

  // One 8-bit down stage; returns borrow-out in the top bit
  function automatic logic [8:0] stage_dec(input logic [7:0] v, input logic en);
    stage_dec = en ? {(v == 8'h00), v - 8'h01} : {1'b0, v};
  endfunction

  always_comb begin
    logic [8:0] lo_n;
    logic [8:0] hi_n;
    lo_n    = '0;
    hi_n    = '0;
    s_d     = s_q;
    evt     = 1'b0;
    elapsed = CNT_FULL - {s_q.cnt_hi, s_q.cnt_lo};
    s_d.out.edge_pulse = 1'b0;
    s_d.div_go         = 1'b0;
    s_d.tick           = 1'b0;

    // Three stages; first flop only feeds the second
    s_d.sync = {s_q.sync[1:0], sensor_flag_input};
    if (s_q.sync[1] == s_q.sync[2]) begin
      if (!s_q.primed) begin
        // Reset level of the sync chain (low) is taken as is; a pin high at power-up then counts as an edge
        s_d.primed = 1'b1;
        s_d.lvl    = s_q.sync[2];
      end else if (s_q.sync[2] != s_q.lvl) begin
        s_d.lvl = s_q.sync[2];
        evt     = 1'b1;
      end
    end
    if (evt) begin
      s_d.out.edge_pulse = 1'b1;
    end
    s_d.out.level = s_d.lvl;

    case (s_q.st)
      ST_IDLE: begin
        if (evt) begin
          s_d.st = ST_CLEAR;
        end
      end
      ST_COUNT: begin
        if (s_q.presc == 8'h00) begin
          s_d.presc = PRESC_LOAD;
          s_d.tick  = 1'b1;
        end else begin
          s_d.presc = s_q.presc - 8'h01;
        end
        // Saturate at full scale so a dead sensor cannot wrap to a short count
        if (s_q.tick && {s_q.cnt_hi, s_q.cnt_lo} != 16'h0000) begin
          lo_n       = stage_dec(s_q.cnt_lo, 1'b1);
          hi_n       = stage_dec(s_q.cnt_hi, lo_n[8]);
          s_d.cnt_lo = lo_n[7:0];
          s_d.cnt_hi = hi_n[7:0];
        end
        if (elapsed[CNT_W-1]) begin
          s_d.out.error = 1'b1;
        end
        if (evt) begin
          s_d.st = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        // New level low means the high phase just ended
        if (!s_q.lvl) begin
          s_d.out.high_period = elapsed;
          s_d.got_hi          = 1'b1;
        end else begin
          s_d.out.low_period = elapsed;
          s_d.got_lo         = 1'b1;
        end
        // A clean phase clears a stale error; set above still wins in count
        s_d.out.error = elapsed[CNT_W-1];
        s_d.out.valid = s_d.got_hi && s_d.got_lo;
        s_d.div_go    = s_d.got_hi && s_d.got_lo;
        s_d.st        = ST_CLEAR;
      end
      ST_CLEAR: begin
        s_d.cnt_hi = CNT_FULL[15:8];
        s_d.cnt_lo = CNT_FULL[7:0];
        s_d.presc  = PRESC_LOAD;
        s_d.st     = ST_COUNT;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Both counts kept at once, divider reads them while they stand
  dctd_ratio_div u_div (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .start   (s_q.div_go),
    .high_in (s_q.out.high_period),
    .low_in  (s_q.out.low_period),
    .result  (temp_w)
  );

  assign meas = s_q.out;
  assign temp = temp_w;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence capture_seq;
    s_q.st == ST_CAPTURE ##1 s_q.st == ST_CLEAR;
  endsequence

  edge_to_capture_a: assert property (
    evt && s_q.st == ST_COUNT |=> s_q.st == ST_CAPTURE)
    else $error("edge not captured");
  edge_pulse_once_a: assert property (
    s_q.out.edge_pulse |=> !s_q.out.edge_pulse)
    else $error("edge pulse longer than one cycle");
  capture_select_a: assert property (
    s_q.st == ST_CAPTURE && !s_q.lvl |=>
      s_q.out.high_period == $past(elapsed) && $stable(s_q.out.low_period))
    else $error("high phase captured in wrong register");
  clear_after_a: assert property (
    capture_seq |=> s_q.st == ST_COUNT && {s_q.cnt_hi, s_q.cnt_lo} == CNT_FULL)
    else $error("counter not reloaded after capture");
  tick_spacing_a: assert property (
    s_q.tick |=> (!s_q.tick)[*8])
    else $error("count enable too frequent");
  tick_period_a: assert property (
    s_q.tick && s_q.st == ST_COUNT |-> ##[1:20] (s_q.tick || s_q.st != ST_COUNT))
    else $error("count enable missing");
  error_msb_a: assert property (
    s_q.st == ST_COUNT && elapsed[15] |=> s_q.out.error)
    else $error("overlong phase not flagged");
  no_partial_a: assert property (
    s_q.st == ST_IDLE |=> $stable(s_q.out.high_period) && $stable(s_q.out.low_period))
    else $error("count captured before first edge");
  valid_both_a: assert property (
    s_q.out.valid |-> s_q.got_hi && s_q.got_lo)
    else $error("valid without both phases");
endmodule

// ===== hw/dctd_pkg.sv
// Constants and carrier types for the duty-cycle thermometer decoder
package dctd_pkg;
  localparam int          CLK_HZ       = 20_000_000;
  localparam int          COUNT_HZ     = 1_000_000;
  localparam logic [7:0]  PRESC_LOAD   = 8'(CLK_HZ / COUNT_HZ - 1);
  localparam int          STAGE_W      = 8;
  localparam int          CNT_W        = 2 * STAGE_W;
  localparam logic [15:0] CNT_FULL     = 16'hffff;
  localparam int          MAX_PHASE_MS = 32;
  localparam int          QUO_W        = 11;
  localparam logic [10:0] TEMP_SCALE   = 11'h640;
  localparam logic [15:0] TEMP_OFFSET  = 16'h03ac;
  localparam logic [3:0]  DIV_LAST     = 4'h0;
  localparam logic [3:0]  DIV_FIRST    = 4'ha;

  typedef enum logic [1:0] {ST_IDLE, ST_COUNT, ST_CAPTURE, ST_CLEAR} dctd_state_t;

  typedef struct packed {
    logic [15:0] high_period;
    logic [15:0] low_period;
    logic        level;
    logic        edge_pulse;
    logic        error;
    logic        valid;
  } dctd_meas_t;

  typedef struct packed {
    logic signed [15:0] temp;
    logic               temp_valid;
    logic               done;
  } dctd_temp_t;
endpackage

// ===== hw/dctd_ratio_div.sv
// Sequential ratio divider producing the 14.2 temperature value
`timescale 1ns/1ps
module dctd_ratio_div (
  input  wire logic           sys_clk,
  input  wire logic           rst_b,
  input  wire logic           start,
  input  wire logic [15:0]    high_in,
  input  wire logic [15:0]    low_in,
  output dctd_pkg::dctd_temp_t result
);
  import dctd_pkg::*;

  typedef struct packed {
    logic        busy;
    logic [3:0]  step;
    logic [27:0] rem;
    logic [15:0] div;
    logic [10:0] quo;
    dctd_temp_t  res;
  } dctd_div_state_t;

  dctd_div_state_t s_q, s_d;
  logic [27:0]     trial;

  always_comb begin
    s_d          = s_q;
    s_d.res.done = 1'b0;
    trial        = 28'(s_q.div) << s_q.step;
    if (!s_q.busy) begin
      if (start) begin
        // Scale 400 by 4 so the quotient already carries two fraction bits
        s_d.busy = 1'b1;
        s_d.step = DIV_FIRST;
        s_d.rem  = 28'(high_in) * 28'(TEMP_SCALE);
        s_d.div  = low_in;
        s_d.quo  = '0;
      end
    end else begin
      // Only 11 quotient bits: ratio below 0.7 keeps 1600*ratio under 2048
      if (s_q.rem >= trial) begin
        s_d.rem = s_q.rem - trial;
        s_d.quo = s_q.quo | (11'h001 << s_q.step);
      end
      if (s_q.step == DIV_LAST) begin
        s_d.busy           = 1'b0;
        s_d.res.temp       = $signed(TEMP_OFFSET - 16'(s_d.quo));
        s_d.res.temp_valid = 1'b1;
        s_d.res.done       = 1'b1;
      end else begin
        s_d.step = s_q.step - 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign result = s_q.res;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  temp_formula_a: assert property (
    s_q.res.done |-> s_q.res.temp == $signed(TEMP_OFFSET - 16'(s_q.quo)))
    else $error("temperature not 940 minus quotient");
  // Start edge loads, eleven steps follow, done registers on the last
  div_latency_a: assert property (
    start && !s_q.busy |-> ##12 s_q.res.done)
    else $error("divider did not finish in 12 cycles");
  // Quotient and remainder must rebuild the scaled high count exactly
  div_exact_a: assert property (
    s_q.res.done && s_q.div != 16'h0000 |->
      28'(s_q.quo) * 28'(s_q.div) + s_q.rem == 28'(high_in) * 28'(TEMP_SCALE)
      && s_q.rem < 28'(s_q.div))
    else $error("quotient does not rebuild the dividend");
endmodule
